// file: shared/nvc_pkg.sv
// Constants for the nonvolatile access controller: register map, fields, reset values, timing.
// Assumes a plain register port with one-cycle strobes and read data one cycle later.
package nvc_pkg;
  localparam logic [2:0] ADDR_DATA_LOW  = 3'h0;
  localparam logic [2:0] ADDR_ADDR_LOW  = 3'h1;
  localparam logic [2:0] ADDR_DATA_HIGH = 3'h2;
  localparam logic [2:0] ADDR_ADDR_HIGH = 3'h3;
  localparam logic [2:0] ADDR_CONTROL   = 3'h4;
  localparam logic [2:0] ADDR_UNLOCK    = 3'h5;
  localparam logic [2:0] ADDR_STATUS    = 3'h6;
  localparam int         AW             = 3;

  localparam int BIT_SPACE = 7;
  localparam int BIT_ABORT = 3;
  localparam int BIT_PERMIT = 2;
  localparam int BIT_STORE = 1;
  localparam int BIT_FETCH = 0;
  localparam int BIT_DONE  = 0;

  localparam logic [7:0] UNLOCK_FIRST  = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
  localparam logic [7:0] RESET_BYTE    = 8'h00;
  localparam logic [3:0] ADDR_HIGH_MASK = 4'hF;
  localparam logic [5:0] DATA_HIGH_MASK = 6'h3F;

  localparam int DATA_DEPTH_FULL  = 256;
  localparam int DATA_DEPTH_SMALL = 128;
  localparam int PROG_DEPTH       = 4096;
  localparam int PROG_WIDTH       = 14;
  localparam int PROG_AW          = 12;

  localparam int STORE_TIME_US    = 5000;
  localparam int CLK_MHZ          = 40;
  localparam int STORE_CYCLES     = STORE_TIME_US * CLK_MHZ;
  localparam int FETCH_DELAY      = 2;

  typedef enum logic [1:0] {NVC_UL_IDLE, NVC_UL_GOT55, NVC_UL_ARMED} nvc_unlock_t;
endpackage : nvc_pkg

// file: design/nvc_sync3.sv
// Three-flop input synchroniser; output changes once stages two and three agree.
// Assumes the input is asynchronous to i_clk.
`timescale 1ns/10ps
module nvc_sync3 (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_async,
  output logic      o_level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_level <= 1'b0;
    end else if (s2_q == s3_q) begin
      o_level <= s3_q;
    end
  end
endmodule : nvc_sync3

// file: design/nvc_access_ctrl.sv
// Nonvolatile access controller: data store byte read/write, program store word read.
// Assumes a CPU-side register port and reset-cause inputs that are asynchronous pins.
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/10ps
// Notes on behaviour
// - Data store holds 256 bytes, or 128 bytes in the small variant.
// - Program access joins data bytes to 14 bits, address bytes to 12.
// - Program store is 4K words, read only, one word per read.
// - A byte write erases then stores the byte, no separate erase.
// - Write duration comes from an internal timer, ends with hardware completion.
// - Code protection never blocks CPU access; only programmer is refused.
// - space_select zero selects data store, one selects program store; resets zero.
// - Trigger bits set by software only, cleared by hardware on completion.
// - store_permit clears at power-up and only software changes it afterwards.
// - store_abort_flag sets when a reset cuts a write short.
// - Completion sets store_done_flag; software clears it.
// - unlock_port has no storage and reads zero.
// - Write starts only after 55h, AAh, then store_trigger set.
// - store_trigger cannot be set unless store_permit is already one.
// - Clearing store_permit mid-write does not affect the write.
// - Data read result lands next cycle and holds until read or write.
// - Data accesses ignore the high address register.
// - High address keeps four bits; upper nibble reads zero.
// - High data keeps six bits; top two bits read zero.
// - Program read fetches in second cycle, data present the cycle after.
// - store_trigger with program store selected clears at once, no operation.
module nvc_access_ctrl #(
  parameter int          STORE_CYCLES = nvc_pkg::STORE_CYCLES,
  parameter logic [13:0] PROG_BLANK   = 14'h3FFF
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic               i_por,
  input  wire logic               i_small_variant,
  input  wire logic               i_code_protect,
  input  wire logic               i_ext_reset_pin,
  input  wire logic               i_watchdog_timeout,
  input  wire logic               i_brownout_reset,
  input  wire logic [nvc_pkg::AW-1:0] i_addr,
  input  wire logic [7:0]         i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic      [7:0]         o_rdata,
  input  wire logic               i_prog_load,
  input  wire logic [11:0]        i_prog_load_addr,
  input  wire logic [13:0]        i_prog_load_data,
  input  wire logic               i_pgm_req,
  output logic                    o_pgm_denied,
  output logic                    o_store_done_flag,
  output logic                    o_suppress_instr
);
  logic [7:0]  data_mem [nvc_pkg::DATA_DEPTH_FULL];
  logic [13:0] prog_mem [nvc_pkg::PROG_DEPTH];

  logic [7:0] data_low_q;
  logic [7:0] addr_low_q;
  logic [5:0] data_high_q;
  logic [3:0] addr_high_q;
  logic       space_q;
  logic       abort_q;
  logic       permit_q;
  logic       store_q;
  logic       fetch_q;
  logic       done_q;
  logic [1:0] fetch_cnt_q;
  logic [31:0] timer_q;
  logic       ext_lvl;
  logic       watchdog_lvl;
  logic       brownout_lvl;
  logic       abort_evt;
  logic [7:0] store_addr_q;
  logic [7:0] store_byte_q;
  nvc_pkg::nvc_unlock_t unlock_q;

  nvc_sync3 u_sync_ext (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_ext_reset_pin),
                        .o_level(ext_lvl));
  nvc_sync3 u_sync_watchdog (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_watchdog_timeout),
                             .o_level(watchdog_lvl));
  nvc_sync3 u_sync_brownout (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_brownout_reset),
                             .o_level(brownout_lvl));

  logic wr_data_low;
  logic wr_addr_low;
  logic wr_data_high;
  logic wr_addr_high;
  logic wr_control;
  logic wr_unlock;
  logic wr_status;
  logic armed;
  logic store_start;
  logic store_end;
  logic fetch_start;
  logic fetch_end;
  logic [7:0] data_addr;
  logic [11:0] prog_addr;

  always_comb begin
    wr_data_low  = 1'b0;
    wr_addr_low  = 1'b0;
    wr_data_high = 1'b0;
    wr_addr_high = 1'b0;
    wr_control   = 1'b0;
    wr_unlock    = 1'b0;
    wr_status    = 1'b0;
    if (i_wr && i_addr == nvc_pkg::ADDR_DATA_LOW) begin
      wr_data_low = 1'b1;
    end else if (i_wr && i_addr == nvc_pkg::ADDR_ADDR_LOW) begin
      wr_addr_low = 1'b1;
    end else if (i_wr && i_addr == nvc_pkg::ADDR_DATA_HIGH) begin
      wr_data_high = 1'b1;
    end else if (i_wr && i_addr == nvc_pkg::ADDR_ADDR_HIGH) begin
      wr_addr_high = 1'b1;
    end else if (i_wr && i_addr == nvc_pkg::ADDR_CONTROL) begin
      wr_control = 1'b1;
    end else if (i_wr && i_addr == nvc_pkg::ADDR_UNLOCK) begin
      wr_unlock = 1'b1;
    end else if (i_wr && i_addr == nvc_pkg::ADDR_STATUS) begin
      wr_status = 1'b1;
    end
  end

  // Small variant wraps the address into the lower 128 bytes; high byte ignored
  assign data_addr = i_small_variant ? {1'b0, addr_low_q[6:0]} : addr_low_q;
  assign prog_addr = {addr_high_q, addr_low_q};

  assign armed       = (unlock_q == nvc_pkg::NVC_UL_ARMED);
  // Write accepted only when armed, permitted, idle, and data store selected
  assign store_start = wr_control && i_wdata[nvc_pkg::BIT_STORE] && !store_q && armed
                       && permit_q && !i_wdata[nvc_pkg::BIT_SPACE];
  assign store_end   = store_q && (timer_q == 32'h0000_0001);
  assign fetch_start = wr_control && i_wdata[nvc_pkg::BIT_FETCH] && !fetch_q && !store_q;
  assign fetch_end   = fetch_q && (fetch_cnt_q == 2'h1);
  assign abort_evt   = ext_lvl || watchdog_lvl || brownout_lvl;

  // Unlock tracker: any other register write drops the sequence
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      unlock_q <= nvc_pkg::NVC_UL_IDLE;
    end else if (i_wr) begin
      case (unlock_q)
        nvc_pkg::NVC_UL_IDLE:  unlock_q <= (wr_unlock && i_wdata == nvc_pkg::UNLOCK_FIRST)
                                 ? nvc_pkg::NVC_UL_GOT55 : nvc_pkg::NVC_UL_IDLE;
        nvc_pkg::NVC_UL_GOT55: unlock_q <= (wr_unlock && i_wdata == nvc_pkg::UNLOCK_SECOND)
                                 ? nvc_pkg::NVC_UL_ARMED : nvc_pkg::NVC_UL_IDLE;
        default:               unlock_q <= nvc_pkg::NVC_UL_IDLE;
      endcase
    end
  end

  // Address registers, low and high
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      addr_low_q  <= nvc_pkg::RESET_BYTE;
      addr_high_q <= 4'h0;
    end else begin
      if (wr_addr_low) begin
        addr_low_q <= i_wdata;
      end
      if (wr_addr_high) begin
        addr_high_q <= i_wdata[3:0] & nvc_pkg::ADDR_HIGH_MASK;
      end
    end
  end

  // Data registers: read results load them, software writes overwrite them
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      data_low_q  <= nvc_pkg::RESET_BYTE;
      data_high_q <= 6'h00;
    end else if (fetch_start && !i_wdata[nvc_pkg::BIT_SPACE] && !space_q) begin
      data_low_q <= data_mem[data_addr];
    end else if (fetch_end) begin
      data_low_q  <= prog_mem[prog_addr][7:0];
      data_high_q <= prog_mem[prog_addr][13:8] & nvc_pkg::DATA_HIGH_MASK;
    end else begin
      if (wr_data_low) begin
        data_low_q <= i_wdata;
      end
      if (wr_data_high) begin
        data_high_q <= i_wdata[5:0];
      end
    end
  end

  // Control bits
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      space_q <= 1'b0;
    end else if (wr_control) begin
      space_q <= i_wdata[nvc_pkg::BIT_SPACE];
    end
  end

  // Permit clears only on power-up; software alone changes it later
  always_ff @(posedge i_clk or posedge i_por) begin
    if (i_por) begin
      permit_q <= 1'b0;
    end else if (wr_control) begin
      permit_q <= i_wdata[nvc_pkg::BIT_PERMIT];
    end
  end

  // Abort flag survives ordinary reset so software can see it afterwards
  always_ff @(posedge i_clk or posedge i_por) begin
    if (i_por) begin
      abort_q <= 1'b0;
    end else if (store_q && abort_evt) begin
      abort_q <= 1'b1;
    end else if (store_end) begin
      abort_q <= 1'b0;
    end else if (wr_control) begin
      abort_q <= i_wdata[nvc_pkg::BIT_ABORT];
    end
  end

  // Write engine: timer runs to completion, abort on synchronised reset causes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      store_q      <= 1'b0;
      timer_q      <= 32'h0;
      store_addr_q <= 8'h00;
      store_byte_q <= 8'h00;
    end else if (store_q && abort_evt) begin
      store_q <= 1'b0;
      timer_q <= 32'h0;
    end else if (store_start) begin
      store_q      <= 1'b1;
      timer_q      <= 32'(STORE_CYCLES);
      store_addr_q <= data_addr;
      store_byte_q <= data_low_q;
    end else if (store_q) begin
      timer_q <= timer_q - 32'h1;
      if (store_end) begin
        store_q <= 1'b0;
      end
    end
  end

  // Byte cell: erase then program collapse into one overwrite at completion
  always_ff @(posedge i_clk) begin
    if (store_end && !abort_evt) begin
      data_mem[store_addr_q] <= store_byte_q;
    end
    if (i_prog_load && !i_code_protect) begin
      prog_mem[i_prog_load_addr] <= i_prog_load_data;
    end
  end

  // Program fetch: two-cycle countdown, suppressed instruction in second cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fetch_q     <= 1'b0;
      fetch_cnt_q <= 2'h0;
    end else if (fetch_start && (i_wdata[nvc_pkg::BIT_SPACE] || space_q)) begin
      fetch_q     <= 1'b1;
      fetch_cnt_q <= 2'(nvc_pkg::FETCH_DELAY);
    end else if (fetch_q) begin
      fetch_cnt_q <= fetch_cnt_q - 2'h1;
      if (fetch_end) begin
        fetch_q <= 1'b0;
      end
    end
  end

  // Done flag: set wins over a software clear in the same cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      done_q <= 1'b0;
    end else if (store_end && !abort_evt) begin
      done_q <= 1'b1;
    end else if (wr_status && !i_wdata[nvc_pkg::BIT_DONE]) begin
      done_q <= 1'b0;
    end
  end

  // Read port
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (!i_rd) begin
      o_rdata <= 8'h00;
    end else if (i_addr == nvc_pkg::ADDR_DATA_LOW) begin
      o_rdata <= data_low_q;
    end else if (i_addr == nvc_pkg::ADDR_ADDR_LOW) begin
      o_rdata <= addr_low_q;
    end else if (i_addr == nvc_pkg::ADDR_DATA_HIGH) begin
      o_rdata <= {2'b00, data_high_q};
    end else if (i_addr == nvc_pkg::ADDR_ADDR_HIGH) begin
      o_rdata <= {4'h0, addr_high_q};
    end else if (i_addr == nvc_pkg::ADDR_CONTROL) begin
      o_rdata <= {space_q, 3'b000, abort_q, permit_q, store_q, fetch_q};
    end else if (i_addr == nvc_pkg::ADDR_STATUS) begin
      o_rdata <= {7'h00, done_q};
    end else begin
      o_rdata <= 8'h00;
    end
  end

  assign o_store_done_flag = done_q;
  assign o_pgm_denied      = i_pgm_req && i_code_protect;
  assign o_suppress_instr  = fetch_end;

  property p_store_needs_permit;
    @(posedge i_clk) disable iff (i_rst)
      $rose(store_q) |-> $past(permit_q) && $past(unlock_q) == nvc_pkg::NVC_UL_ARMED;
  endproperty
  a_store_needs_permit: assert property (p_store_needs_permit)
    else $error("write without unlock");

  property p_done_on_end;
    @(posedge i_clk) disable iff (i_rst) (store_end && !abort_evt) |=> done_q && !store_q;
  endproperty
  a_done_on_end: assert property (p_done_on_end) else $error("done not set");

  sequence s_fetch_go;
    fetch_start && (i_wdata[nvc_pkg::BIT_SPACE] || space_q);
  endsequence
  property p_fetch_two;
    @(posedge i_clk) disable iff (i_rst) s_fetch_go |=> fetch_q ##1 fetch_end ##1 !fetch_q;
  endproperty
  a_fetch_two: assert property (p_fetch_two) else $error("program fetch timing wrong");

  property p_no_prog_store;
    @(posedge i_clk) disable iff (i_rst)
      (wr_control && i_wdata[nvc_pkg::BIT_SPACE]) |=> !$rose(store_q);
  endproperty
  a_no_prog_store: assert property (p_no_prog_store)
    else $error("store on program space");

  property p_unlock_reads_zero;
    @(posedge i_clk) disable iff (i_rst)
      (i_rd && i_addr == nvc_pkg::ADDR_UNLOCK) |=> o_rdata == 8'h00;
  endproperty
  a_unlock_reads_zero: assert property (p_unlock_reads_zero)
    else $error("unlock reads nonzero");

  property p_store_holds;
    @(posedge i_clk) disable iff (i_rst) (store_q && !store_end && !abort_evt) |=> store_q;
  endproperty
  a_store_holds: assert property (p_store_holds) else $error("write cut short");

  property p_high_zero;
    @(posedge i_clk) disable iff (i_rst)
      (i_rd && i_addr == nvc_pkg::ADDR_ADDR_HIGH) |=> o_rdata[7:4] == 4'h0;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("high address upper bits set");

  property p_abort_sets;
    @(posedge i_clk) disable iff (i_rst) (store_q && abort_evt) |=> abort_q && !store_q;
  endproperty
  a_abort_sets: assert property (p_abort_sets) else $error("abort flag missing");
endmodule : nvc_access_ctrl

// file: tb/nvc_access_ctrl_tb.sv
// Self-checking bench for the nonvolatile access controller.
// Assumes the register port drives one-cycle strobes, read data valid the cycle after.
`timescale 1ns/10ps
module nvc_access_ctrl_tb;
  localparam int STORE_LEN = 16;
  logic        i_clk              = 1'b0;
  logic        i_rst              = 1'b1;
  logic        i_por              = 1'b1;
  logic        i_small_variant    = 1'b0;
  logic        i_code_protect     = 1'b0;
  logic        i_ext_reset_pin    = 1'b0;
  logic        i_watchdog_timeout = 1'b0;
  logic        i_brownout_reset   = 1'b0;
  logic [2:0]  i_addr             = 3'h0;
  logic [7:0]  i_wdata            = 8'h00;
  logic        i_wr               = 1'b0;
  logic        i_rd               = 1'b0;
  logic        i_prog_load        = 1'b0;
  logic [11:0] i_prog_load_addr   = 12'h000;
  logic [13:0] i_prog_load_data   = 14'h0000;
  logic        i_pgm_req          = 1'b0;
  logic [7:0]  o_rdata;
  logic        o_pgm_denied;
  logic        o_store_done_flag;
  logic        o_suppress_instr;
  int          error_cnt          = 0;
  int          total_checks       = 0;

  always #12.5 i_clk = ~i_clk;

  nvc_access_ctrl #(.STORE_CYCLES(STORE_LEN)) i_nvc_access_ctrl (
    .i_clk              (i_clk),
    .i_rst              (i_rst),
    .i_por              (i_por),
    .i_small_variant    (i_small_variant),
    .i_code_protect     (i_code_protect),
    .i_ext_reset_pin    (i_ext_reset_pin),
    .i_watchdog_timeout (i_watchdog_timeout),
    .i_brownout_reset   (i_brownout_reset),
    .i_addr             (i_addr),
    .i_wdata            (i_wdata),
    .i_wr               (i_wr),
    .i_rd               (i_rd),
    .o_rdata            (o_rdata),
    .i_prog_load        (i_prog_load),
    .i_prog_load_addr   (i_prog_load_addr),
    .i_prog_load_data   (i_prog_load_data),
    .i_pgm_req          (i_pgm_req),
    .o_pgm_denied       (o_pgm_denied),
    .o_store_done_flag  (o_store_done_flag),
    .o_suppress_instr   (o_suppress_instr)
  );

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1;
    v = o_rdata;
  endtask : rd

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp, input string what);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp, what);
  endtask : rchk

  task automatic start_store;
    wr(nvc_pkg::ADDR_UNLOCK, 8'h55);
    wr(nvc_pkg::ADDR_UNLOCK, 8'hAA);
    wr(nvc_pkg::ADDR_CONTROL, 8'h06);
  endtask : start_store

  task automatic wait_idle(output logic [7:0] v);
    int n;
    for (n = 0; n < 200; n++) begin
      rd(nvc_pkg::ADDR_CONTROL, v);
      if (v[nvc_pkg::BIT_STORE] === 1'b0) return;
    end
    error_cnt++;
    $display("MISMATCH at %0t: store never finished", $time);
    wrap_up();
  endtask : wait_idle

  task automatic load(input logic [11:0] a, input logic [13:0] d);
    @(posedge i_clk);
    i_prog_load      <= 1'b1;
    i_prog_load_addr <= a;
    i_prog_load_data <= d;
    @(posedge i_clk);
    i_prog_load      <= 1'b0;
  endtask : load

  task automatic t_reset;
    for (int a = 0; a < 7; a++) rchk(3'(a), 8'h00, "reset value");
    wr(nvc_pkg::ADDR_UNLOCK, 8'h55);
    rchk(nvc_pkg::ADDR_UNLOCK, 8'h00, "unlock port read");
    $display("test reset done");
  endtask : t_reset

  task automatic t_masks;
    wr(nvc_pkg::ADDR_ADDR_HIGH, 8'hFF);
    rchk(nvc_pkg::ADDR_ADDR_HIGH, 8'h0F, "high address mask");
    wr(nvc_pkg::ADDR_DATA_HIGH, 8'hFF);
    rchk(nvc_pkg::ADDR_DATA_HIGH, 8'h3F, "high data mask");
    $display("test masks done");
  endtask : t_masks

  task automatic t_write;
    logic [7:0] v;
    wr(nvc_pkg::ADDR_ADDR_HIGH, 8'h05);
    wr(nvc_pkg::ADDR_ADDR_LOW, 8'h3C);
    wr(nvc_pkg::ADDR_DATA_LOW, 8'hA5);
    wr(nvc_pkg::ADDR_CONTROL, 8'h04);
    start_store();
    rchk(nvc_pkg::ADDR_CONTROL, 8'h06, "store busy");
    wr(nvc_pkg::ADDR_CONTROL, 8'h00);
    rchk(nvc_pkg::ADDR_CONTROL, 8'h02, "store kept after permit cleared");
    wait_idle(v);
    rchk(nvc_pkg::ADDR_STATUS, 8'h01, "done flag set");
    chk({7'h00, o_store_done_flag}, 8'h01, "done output set");
    wr(nvc_pkg::ADDR_STATUS, 8'h00);
    rchk(nvc_pkg::ADDR_STATUS, 8'h00, "done flag cleared");
    chk({7'h00, o_store_done_flag}, 8'h00, "done output cleared");
    // Complementary byte over the old one shows the erase step
    wr(nvc_pkg::ADDR_DATA_LOW, 8'h5A);
    wr(nvc_pkg::ADDR_CONTROL, 8'h04);
    start_store();
    wait_idle(v);
    wr(nvc_pkg::ADDR_DATA_LOW, 8'h00);
    wr(nvc_pkg::ADDR_ADDR_HIGH, 8'h0A);
    wr(nvc_pkg::ADDR_CONTROL, 8'h05);
    rchk(nvc_pkg::ADDR_DATA_LOW, 8'h5A, "byte read back");
    rchk(nvc_pkg::ADDR_CONTROL, 8'h04, "fetch bit self clears");
    rchk(nvc_pkg::ADDR_DATA_LOW, 8'h5A, "read byte holds");
    wr(nvc_pkg::ADDR_STATUS, 8'h00);
    $display("test write done");
  endtask : t_write

  task automatic t_refuse;
    wr(nvc_pkg::ADDR_CONTROL, 8'h00);
    start_store();
    rchk(nvc_pkg::ADDR_CONTROL, 8'h04, "store without permit");
    wr(nvc_pkg::ADDR_CONTROL, 8'h04);
    wr(nvc_pkg::ADDR_UNLOCK, 8'h55);
    wr(nvc_pkg::ADDR_ADDR_LOW, 8'h3C);
    wr(nvc_pkg::ADDR_UNLOCK, 8'hAA);
    wr(nvc_pkg::ADDR_CONTROL, 8'h06);
    rchk(nvc_pkg::ADDR_CONTROL, 8'h04, "broken unlock");
    wr(nvc_pkg::ADDR_UNLOCK, 8'hAA);
    wr(nvc_pkg::ADDR_UNLOCK, 8'h55);
    wr(nvc_pkg::ADDR_CONTROL, 8'h06);
    rchk(nvc_pkg::ADDR_CONTROL, 8'h04, "reversed unlock");
    rchk(nvc_pkg::ADDR_STATUS, 8'h00, "no write done");
    $display("test refuse done");
  endtask : t_refuse

  task automatic t_prog;
    load(12'hFFF, 14'h2C5A);
    wr(nvc_pkg::ADDR_ADDR_HIGH, 8'h0F);
    wr(nvc_pkg::ADDR_ADDR_LOW, 8'hFF);
    wr(nvc_pkg::ADDR_CONTROL, 8'h85);
    #1;
    chk({7'h00, o_suppress_instr}, 8'h00, "suppress early");
    @(posedge i_clk);
    #1;
    chk({7'h00, o_suppress_instr}, 8'h01, "suppress slot");
    @(posedge i_clk);
    #1;
    chk({7'h00, o_suppress_instr}, 8'h00, "suppress late");
    rchk(nvc_pkg::ADDR_DATA_LOW, 8'h5A, "program word low");
    rchk(nvc_pkg::ADDR_DATA_HIGH, 8'h2C, "program word high");
    rchk(nvc_pkg::ADDR_CONTROL, 8'h84, "fetch clears");
    // Unlocked and permitted, so only the program space selection refuses the store
    wr(nvc_pkg::ADDR_UNLOCK, 8'h55);
    wr(nvc_pkg::ADDR_UNLOCK, 8'hAA);
    wr(nvc_pkg::ADDR_CONTROL, 8'h86);
    rchk(nvc_pkg::ADDR_CONTROL, 8'h84, "store on program space");
    rchk(nvc_pkg::ADDR_STATUS, 8'h00, "no program write");
    @(posedge i_clk);
    i_code_protect <= 1'b1;
    i_pgm_req      <= 1'b1;
    load(12'hFFF, 14'h0123);
    #1;
    chk({7'h00, o_pgm_denied}, 8'h01, "programmer denied");
    wr(nvc_pkg::ADDR_CONTROL, 8'h81);
    repeat (3) @(posedge i_clk);
    rchk(nvc_pkg::ADDR_DATA_LOW, 8'h5A, "protected load ignored");
    @(posedge i_clk);
    i_code_protect <= 1'b0;
    #1;
    chk({7'h00, o_pgm_denied}, 8'h00, "programmer allowed");
    @(posedge i_clk);
    i_pgm_req      <= 1'b0;
    wr(nvc_pkg::ADDR_CONTROL, 8'h00);
    $display("test program done");
  endtask : t_prog

  task automatic t_abort;
    logic [7:0] v;
    for (int k = 0; k < 3; k++) begin
      wr(nvc_pkg::ADDR_CONTROL, 8'h04);
      start_store();
      @(posedge i_clk);
      {i_brownout_reset, i_watchdog_timeout, i_ext_reset_pin} <= 3'(3'h1 << k);
      repeat (5) @(posedge i_clk);
      {i_brownout_reset, i_watchdog_timeout, i_ext_reset_pin} <= 3'h0;
      repeat (6) @(posedge i_clk);
      rd(nvc_pkg::ADDR_CONTROL, v);
      chk(v & 8'h0A, 8'h08, "abort flag");
    end
    $display("test abort done");
  endtask : t_abort

  task automatic t_small;
    logic [7:0] v;
    @(posedge i_clk);
    i_small_variant <= 1'b1;
    wr(nvc_pkg::ADDR_ADDR_LOW, 8'h85);
    wr(nvc_pkg::ADDR_DATA_LOW, 8'h77);
    wr(nvc_pkg::ADDR_CONTROL, 8'h04);
    start_store();
    wait_idle(v);
    chk(v, 8'h04, "abort flag clear after good write");
    wr(nvc_pkg::ADDR_ADDR_LOW, 8'h05);
    wr(nvc_pkg::ADDR_DATA_LOW, 8'h00);
    wr(nvc_pkg::ADDR_CONTROL, 8'h01);
    rchk(nvc_pkg::ADDR_DATA_LOW, 8'h77, "small store wraps");
    $display("test small done");
  endtask : t_small

  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    i_por <= 1'b0;
    t_reset();
    t_masks();
    t_write();
    t_refuse();
    t_prog();
    t_abort();
    t_small();
    wrap_up();
  end
endmodule : nvc_access_ctrl_tb
